//--- inc/sjtap_pkg.sv
// package for the sram test access port: states, instruction codes, widths
// assumes a single system clock sampling the test pins
package sjtap_pkg;
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
		ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
		ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} sjtap_state_t;
	localparam int IR_W = 3;
	localparam int ID_W = 32;
	localparam int BSR_W = 109;
	localparam int RESET_TMS_EDGES = 5;
	localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
	localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
	localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
	// arbitrary identification value
	localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5a5001;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} sjtap_pins_t;
endpackage

//--- logic/sjtap_port.sv
// test access port of a memory, clocked by the system clock
// assumes test pins asynchronous; RST_B_I stands for power-up
`timescale 1ns/10ps
module sjtap_port
	import sjtap_pkg::*;
#(
	parameter int BSR_LEN = sjtap_pkg::BSR_W
) (
	// system
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	// test pins
	input wire sjtap_pkg::sjtap_pins_t PINS_I,
	output logic TDO_O,
	output logic TDO_OE_O,
	// memory side
	input wire logic [BSR_LEN-1:0] MEM_PINS_I,
	output logic MEM_HIZ_O,
	output logic [BSR_LEN-1:0] BSR_UPD_O,
	output logic EXTEST_O
);
	import sjtap_pkg::*;
	// the boundary shift below needs at least two cells
	if (BSR_LEN < 2) begin : g_len_check
		$error("boundary length must be at least two");
	end
	logic [2:0] pin_s;
	logic tck_q;
	logic rise, fall;
	sjtap_state_t st, next_st;
	logic [IR_W-1:0] ir, next_ir, irs, next_irs;
	logic [ID_W-1:0] idr, next_idr;
	logic byp, next_byp;
	logic [BSR_LEN-1:0] bsr, next_bsr, upd, next_upd;
	logic tdo_r, next_tdo, oe_r, next_oe, hiz, next_hiz, ext, next_ext;
	logic ser;
	sjtap_sync #(.W(3), .INIT(3'h3)) u_sync (
		.clk_i(CLK_SYS_I),
		.rst_b_i(RST_B_I),
		.d_i({PINS_I.tck, PINS_I.tms, PINS_I.tdi}),
		.q_o(pin_s)
	);
	// tck is seen low and tms, tdi high at the synchroniser output via reset value
	wire tck_s = pin_s[2];
	wire tms_s = pin_s[1];
	wire tdi_s = pin_s[0];
	assign rise = tck_s & ~tck_q;
	assign fall = ~tck_s & tck_q;
	always_comb begin
		next_st = st;
		if (rise) begin
			unique case (st)
				ST_RESET: next_st = tms_s ? ST_RESET : ST_IDLE;
				ST_IDLE: next_st = tms_s ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR: next_st = tms_s ? ST_SEL_IR : ST_CAP_DR;
				ST_CAP_DR: next_st = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_SHIFT_DR: next_st = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_EXIT1_DR: next_st = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
				ST_PAUSE_DR: next_st = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
				ST_EXIT2_DR: next_st = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
				ST_UPD_DR: next_st = tms_s ? ST_SEL_DR : ST_IDLE;
				ST_SEL_IR: next_st = tms_s ? ST_RESET : ST_CAP_IR;
				ST_CAP_IR: next_st = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_SHIFT_IR: next_st = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_EXIT1_IR: next_st = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
				ST_PAUSE_IR: next_st = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
				ST_EXIT2_IR: next_st = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
				ST_UPD_IR: next_st = tms_s ? ST_SEL_DR : ST_IDLE;
			endcase
		end
	end
	always_comb begin
		next_ir = ir;
		next_irs = irs;
		next_idr = idr;
		next_byp = byp;
		next_bsr = bsr;
		next_upd = upd;
		if (rise) begin
			unique case (st)
				ST_RESET: next_ir = INS_IDCODE;
				ST_CAP_IR: next_irs = IR_CAPTURE;
				ST_SHIFT_IR: next_irs = {tdi_s, irs[IR_W-1:1]};
				ST_UPD_IR: next_ir = irs;
				ST_CAP_DR: begin
					next_byp = 1'b0;
					if (ir == INS_IDCODE) begin
						next_idr = ID_VALUE;
					end
					if (ir == INS_SAMPLE_Z || ir == INS_SAMPLE || ir == INS_EXTEST) begin
						next_bsr = MEM_PINS_I;
					end
				end
				ST_SHIFT_DR: begin
					if (ir == INS_IDCODE) begin
						next_idr = {tdi_s, idr[ID_W-1:1]};
					end else if (ir == INS_SAMPLE_Z || ir == INS_SAMPLE
						|| ir == INS_EXTEST) begin
						next_bsr = {tdi_s, bsr[BSR_LEN-1:1]};
					end else begin
						next_byp = tdi_s;
					end
				end
				ST_UPD_DR: begin
					if (ir == INS_EXTEST || ir == INS_SAMPLE) begin
						next_upd = bsr;
					end
				end
				default: begin
				end
			endcase
		end
		// identify instruction stands from the second cycle in reset, even if the clock stops
		if (st == ST_RESET) begin
			next_ir = INS_IDCODE;
		end
	end
	// serial source chosen by state and instruction
	always_comb begin
		if (st == ST_SHIFT_IR) begin
			ser = irs[0];
		end else if (ir == INS_IDCODE) begin
			ser = idr[0];
		end else if (ir == INS_SAMPLE_Z || ir == INS_SAMPLE || ir == INS_EXTEST) begin
			ser = bsr[0];
		end else begin
			ser = byp;
		end
	end
	always_comb begin
		next_tdo = tdo_r;
		next_oe = oe_r;
		next_hiz = (ir == INS_SAMPLE_Z);
		next_ext = (ir == INS_EXTEST);
		if (fall) begin
			next_oe = (st == ST_SHIFT_IR) || (st == ST_SHIFT_DR);
			next_tdo = ser;
		end
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			tck_q <= 1'b0;
			st <= ST_RESET;
			ir <= INS_IDCODE;
			irs <= '0;
			idr <= '0;
			byp <= 1'b0;
			bsr <= '0;
			upd <= '0;
			tdo_r <= 1'b0;
			oe_r <= 1'b0;
			hiz <= 1'b0;
			ext <= 1'b0;
		end else begin
			tck_q <= tck_s;
			st <= next_st;
			ir <= next_ir;
			irs <= next_irs;
			idr <= next_idr;
			byp <= next_byp;
			bsr <= next_bsr;
			upd <= next_upd;
			tdo_r <= next_tdo;
			oe_r <= next_oe;
			hiz <= next_hiz;
			ext <= next_ext;
		end
	end
	assign TDO_O = tdo_r;
	assign TDO_OE_O = oe_r;
	assign MEM_HIZ_O = hiz;
	assign BSR_UPD_O = upd;
	assign EXTEST_O = ext;
	// helper: count consecutive high mode-select rises
	logic [2:0] hi_cnt, next_hi_cnt;
	always_comb begin
		next_hi_cnt = hi_cnt;
		if (rise) begin
			if (!tms_s) begin
				next_hi_cnt = 3'h0;
			end else if (hi_cnt != 3'(RESET_TMS_EDGES)) begin
				next_hi_cnt = hi_cnt + 3'h1;
			end
		end
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			hi_cnt <= '0;
		end else begin
			hi_cnt <= next_hi_cnt;
		end
	end
	property p_five_reset;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
			(hi_cnt == 3'(RESET_TMS_EDGES)) |-> (st == ST_RESET);
	endproperty
	a_five_reset: assert property (p_five_reset) else $error("no reset after five highs");
	property p_tdo_on_fall;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I) !$past(fall) |-> $stable(TDO_O);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("data-out moved off fall");
	property p_state_hold;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I) !$past(rise) |-> $stable(st);
	endproperty
	a_state_hold: assert property (p_state_hold) else $error("state moved without rise");
	property p_reset_ir;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
			(st == ST_RESET) |=> (ir == INS_IDCODE);
	endproperty
	a_reset_ir: assert property (p_reset_ir) else $error("ir not preloaded");
	property p_tms_steers;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
			(rise && st == ST_IDLE && !tms_s) |=> (st == ST_IDLE);
	endproperty
	a_tms_steers: assert property (p_tms_steers) else $error("idle left with low select");
	property p_upd_ir;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
			(rise && st == ST_UPD_IR) |=> (ir == $past(irs));
	endproperty
	a_upd_ir: assert property (p_upd_ir) else $error("ir not updated");
	property p_bypass;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
			(rise && st == ST_SHIFT_DR && ir == INS_BYPASS) |=> (byp == $past(tdi_s));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass bit wrong");
	property p_hiz;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
			(ir == INS_SAMPLE_Z) |=> MEM_HIZ_O;
	endproperty
	a_hiz: assert property (p_hiz) else $error("outputs not floated");
	property p_oe;
		@(posedge CLK_SYS_I) disable iff (!RST_B_I)
			(fall && st == ST_SHIFT_DR) |=> (TDO_OE_O && TDO_O == $past(ser));
	endproperty
	a_oe: assert property (p_oe) else $error("shift output wrong");
	property p_powerup;
		@(posedge CLK_SYS_I) $rose(RST_B_I) |-> (st == ST_RESET && ir == INS_IDCODE);
	endproperty
	a_powerup: assert property (p_powerup) else $error("not reset at power-up");
endmodule

//--- logic/sjtap_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to clk_i
`timescale 1ns/10ps
module sjtap_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1, s2, s3, next_q;
	always_comb begin
		next_q = q_o;
		for (int i = 0; i < W; i++) begin
			if (s2[i] == s3[i]) begin
				next_q[i] = s2[i];
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q_o <= INIT;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= next_q;
		end
	end
endmodule

//--- testbench/sjtap_ctrl.sv
// behavioural boundary-scan controller driving the test pins
// assumes one bench process calls step at a time
`timescale 1ns/10ps
module sjtap_ctrl
	import sjtap_pkg::*;
(
	// test pins
	output sjtap_pkg::sjtap_pins_t pins_o,
	input wire logic tdo_i
);
	// test clock parked low, pulled-up lines read high
	initial begin
		pins_o = 3'h3;
	end
	// one 125 ns test clock period, 60 ns low then 65 ns high; every pin change
	// falls 2.5 ns off a system clock edge; q is tdo just before the rise
	task automatic step(input logic tms, input logic tdi, output logic q, output logic ok);
		#2.5;
		pins_o.tms = tms;
		pins_o.tdi = tdi;
		#50;
		q = tdo_i;
		pins_o.tck = 1'b1;
		#65;
		ok = (tdo_i === q);
		pins_o.tck = 1'b0;
		#7.5;
	endtask
endmodule

//--- testbench/tb_sjtap_port.sv
// self-checking bench for the memory test access port
// assumes sjtap_ctrl as the far-side controller
`timescale 1ns/10ps
module tb_sjtap_port;
	import sjtap_pkg::*;
	localparam int BL = 12;
	logic clk_sys, rst_b, tdo, tdo_oe, hiz, extest;
	sjtap_pins_t pins;
	logic [BL-1:0] mem_pins, bsr_upd;
	int mismatches = 0;
	int n_compared = 0;
	sjtap_port #(.BSR_LEN(BL)) i_sjtap_port (
		.CLK_SYS_I(clk_sys),
		.RST_B_I(rst_b),
		.PINS_I(pins),
		.TDO_O(tdo),
		.TDO_OE_O(tdo_oe),
		.MEM_PINS_I(mem_pins),
		.MEM_HIZ_O(hiz),
		.BSR_UPD_O(bsr_upd),
		.EXTEST_O(extest)
	);
	sjtap_ctrl i_sjtap_ctrl (.pins_o(pins), .tdo_i(tdo));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// n test clocks with mode-select bits taken lsb first
	task automatic walk(input int n, input logic [7:0] tms);
		logic q, ok;
		for (int i = 0; i < n; i++) begin
			i_sjtap_ctrl.step(tms[i], 1'b0, q, ok);
		end
	endtask
	// idle to shift, n bits lsb first, then update and back to idle
	task automatic scan(input logic ir, input int n, input logic [127:0] din,
		output logic [127:0] dout);
		logic q, ok;
		walk(ir ? 4 : 3, ir ? 8'h3 : 8'h1);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			i_sjtap_ctrl.step(i == n - 1, din[i], q, ok);
			dout[i] = q;
			chk("tdo steady while tck high", 128'h1, 128'(ok));
			chk("tdo enable in shift", 128'h1, 128'(tdo_oe));
		end
		walk(2, 8'h1);
		chk("tdo enable after shift", 128'h0, 128'(tdo_oe));
	endtask
	task automatic load_ir(input logic [IR_W-1:0] code);
		logic [127:0] cap;
		scan(1'b1, IR_W, 128'(code), cap);
		chk("ir capture", 128'(IR_CAPTURE), cap);
	endtask
	task automatic t_idcode();
		logic [127:0] d;
		walk(1, 8'h0);
		scan(1'b0, ID_W, 128'h0, d);
		chk("id after power-up", 128'(ID_VALUE), d);
	endtask
	task automatic t_bypass();
		logic [127:0] d;
		load_ir(INS_BYPASS);
		scan(1'b0, 4, 128'hb, d);
		chk("bypass path", 128'h6, d);
	endtask
	task automatic t_codes();
		for (int c = 0; c < 8; c++) begin
			load_ir(IR_W'(c));
			chk("float flag", 128'(c == 2), 128'(hiz));
			chk("extest flag", 128'(c == 0), 128'(extest));
		end
	endtask
	task automatic t_extest();
		logic [127:0] d;
		load_ir(INS_EXTEST);
		scan(1'b0, BL, 128'h3c9, d);
		chk("extest capture", 128'h0, d);
		chk("boundary update", 128'h3c9, 128'(bsr_upd));
	endtask
	task automatic t_hiz();
		logic [127:0] d;
		@(negedge clk_sys);
		mem_pins = 12'ha5c;
		load_ir(INS_SAMPLE_Z);
		chk("outputs floated", 128'h1, 128'(hiz));
		scan(1'b0, BL, 128'h0, d);
		chk("boundary capture", 128'(mem_pins), d);
	endtask
	task automatic t_reset5();
		logic [127:0] d;
		load_ir(INS_SAMPLE_Z);
		walk(3, 8'h1);
		walk(4, 8'hf);
		chk("float after four highs", 128'h1, 128'(hiz));
		walk(2, 8'h1);
		chk("float after reset", 128'h0, 128'(hiz));
		scan(1'b0, ID_W, 128'h0, d);
		chk("id after reset", 128'(ID_VALUE), d);
	endtask
	initial begin
		rst_b = 1'b0;
		mem_pins = '0;
		repeat (16) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (5) @(negedge clk_sys);
		t_idcode();
		t_bypass();
		t_codes();
		t_extest();
		t_hiz();
		t_reset5();
		give_verdict();
	end
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end
endmodule
